// *** design/monitor_select.sv ***
`timescale 1ns/1ps
`include "ref_gate_cfg.svh"
module monitor_select
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// Selection
	input  wire ref_gate_pkg::loop_mode_t loopMode,
	input  wire logic                    trqSel,
	input  wire logic                    vtgSel,
	input  wire logic                    errCoarse,
	// Sources
	input  wire ref_gate_pkg::mon_t      motorTorque,
	input  wire ref_gate_pkg::mon_t      motorSpeed,
	input  wire ref_gate_pkg::mon_t      speedRef,
	input  wire ref_gate_pkg::count_t    refSpeed,
	input  wire ref_gate_pkg::count_t    posError,
	// Monitor words
	output ref_gate_pkg::mon_t           torqueMonitorOut,
	output ref_gate_pkg::mon_t           speedMonitorOut
);
	import ref_gate_pkg::*;

	mon_t   trq_q, trq_d, spd_q, spd_d;
	count_t errScaled;

	function automatic mon_t sat16(input count_t v);
		if (v > 32'sh0000_7fff)
			return 16'sh7fff;
		else if (v < -32'sh0000_8000)
			return -16'sh8000;
		else
			return v[15:0];
	endfunction : sat16

	// ----------------------------------------
	// Source choice; undefined picks read zero
	// ----------------------------------------
	always_comb
	begin
		errScaled = errCoarse ? posError / `ERR_COARSE_DIV : posError;
		trq_d = motorTorque;
		if (trqSel)
		begin
			case (loopMode)
				LOOP_SPEED:    trq_d = speedRef;
				LOOP_POSITION: trq_d = sat16(refSpeed);
				default:       trq_d = 16'sh0000;
			endcase
		end
		spd_d = motorSpeed;
		if (vtgSel)
			spd_d = (loopMode == LOOP_POSITION) ? sat16(errScaled) : 16'sh0000;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			trq_q <= 16'sh0000;
			spd_q <= 16'sh0000;
		end
		else
		begin
			trq_q <= trq_d;
			spd_q <= spd_d;
		end
	end

	assign torqueMonitorOut = trq_q;
	assign speedMonitorOut = spd_q;

	a_trq_default: assert property (@(posedge clk_sys) disable iff (rst)
		!rst && !trqSel |=> torqueMonitorOut == $past(motorTorque))
		else $error("torque monitor not showing motor torque");

	a_err_scale: assert property (@(posedge clk_sys) disable iff (rst)
		vtgSel && loopMode == LOOP_POSITION && errCoarse
		|=> speedMonitorOut == sat16($past(posError) / `ERR_COARSE_DIV))
		else $error("coarse error monitor wrong");
endmodule : monitor_select

// *** design/pulse_filter.sv ***
`timescale 1ns/1ps
`include "ref_gate_cfg.svh"
module pulse_filter
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Raw level and filter choice
	input  wire logic rawIn,
	input  wire logic openCollector,
	// Filtered level
	output logic      cleanOut
);
	import ref_gate_pkg::*;

	logic [4:0] cnt_q, cnt_d;
	logic       clean_q, clean_d;
	logic [4:0] limit;

	// ----------------------------------------
	// Level accepted after a stable run
	// ----------------------------------------
	always_comb
	begin
		limit = openCollector ? 5'(`FILT_OC_CYC) : 5'(`FILT_LD_CYC);
		cnt_d = 5'h00;
		clean_d = clean_q;
		if (rawIn != clean_q)
		begin
			if (cnt_q + 5'h01 >= limit)
				clean_d = rawIn;
			else
				cnt_d = cnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 5'h00;
			clean_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			clean_q <= clean_d;
		end
	end

	assign cleanOut = clean_q;

	a_filter_run: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(clean_q) |-> $past(rawIn, 1) == clean_q && $past(cnt_q) != 5'h00
		|| $past(limit) == 5'h01)
		else $error("filtered level changed without a stable run");
endmodule : pulse_filter

// *** design/ref_gate_cfg.svh ***
`ifndef REF_GATE_CFG_SVH
`define REF_GATE_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_FSW2      5'h00
`define ADDR_CMS       5'h04
`define ADDR_TRG       5'h08
`define ADDR_LOOP      5'h0c
`define ADDR_STATUS    5'h10
`define ADDR_REFCNT    5'h14
`define ADDR_POSERR    5'h18
`define ADDR_REFSPD    5'h1c

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FSW2_TRQ_SEL   6
`define FSW2_VTG_SEL   7
`define FSW2_ERR_SCALE 14
`define FSW2_FILT_OC   15
`define FSW2_RESET     16'h0000
`define CMS_RESET      16'h0000
`define CMS_PI_LO      16'h0000
`define CMS_PI_HI      16'h0001
`define CMS_INHIBIT    16'h000b
`define TRG_RESET      16'h001e
`define TRG_MIN        16'h000a
`define TRG_MAX        16'h0064
`define ERR_COARSE_DIV 32'sh0000_0064

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS         10
`define FILT_LD_NS     100
`define FILT_OC_NS     250
`define FILT_LD_CYC    ((`FILT_LD_NS + `CLK_NS - 1) / `CLK_NS)
`define FILT_OC_CYC    ((`FILT_OC_NS + `CLK_NS - 1) / `CLK_NS)
`define SPD_WIN_NS     1000000
`define SPD_WIN_CYC    (`SPD_WIN_NS / `CLK_NS)

`endif

// *** design/ref_gate_pkg.sv ***
package ref_gate_pkg;
	typedef enum logic [1:0]
	{
		LOOP_SPEED    = 2'h0,
		LOOP_TORQUE   = 2'h1,
		LOOP_POSITION = 2'h2
	} loop_mode_t;

	typedef enum logic [1:0]
	{
		GATE_COUNT = 2'b01,
		GATE_HOLD  = 2'b10
	} gate_state_t;

	typedef logic signed [31:0] count_t;
	typedef logic signed [15:0] mon_t;
endpackage : ref_gate_pkg

// *** design/ref_gate_top.sv ***
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "ref_gate_cfg.svh"
module ref_gate_top
#(
	parameter int SPD_WIN_CYC = `SPD_WIN_CYC
)
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// Avalon-MM slave
	input  wire logic [4:0]              avsAddress,
	input  wire logic                    avsRead,
	input  wire logic                    avsWrite,
	input  wire logic [31:0]             avsWriteData,
	input  wire logic [3:0]              avsByteEnable,
	output logic      [31:0]             avsReadData,
	output logic                         avsWaitRequest,
	// Pulse pins and mode switch
	input  wire logic                    refPulseIn,
	input  wire logic                    refDirIn,
	input  wire logic                    fbPulseIn,
	input  wire logic                    fbDirIn,
	input  wire logic                    modeSwitchOn,
	// Drive quantities
	input  wire ref_gate_pkg::mon_t      motorTorque,
	input  wire ref_gate_pkg::mon_t      motorSpeed,
	input  wire ref_gate_pkg::mon_t      speedRef,
	input  wire logic [15:0]             torqueLimitMv,
	// Drive control
	output logic                         servoClamp,
	output logic                         speedLoopPi,
	output logic [15:0]                  torqueLimitPct,
	// Analog monitor words
	output ref_gate_pkg::mon_t           torqueMonitorOut,
	output ref_gate_pkg::mon_t           speedMonitorOut
);
	import ref_gate_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [15:0] fsw2_q, fsw2_d;
	logic [15:0] cms_q, cms_d;
	logic [15:0] trg_q, trg_d;
	loop_mode_t  loop_q, loop_d;
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        busReq, wrTake;

	gate_state_t gate_q, gate_d;
	logic        inhibitSel, holdNow;
	logic        refClean, dirClean, refPrev_q, fbPrev_q;
	logic        refEdge, fbEdge;
	count_t      refCnt_q, refCnt_d, fbCnt_q, fbCnt_d, posError;
	count_t      winPulse_q, winPulse_d, refSpd_q, refSpd_d;
	logic [31:0] win_q, win_d;
	logic        clamp_d, pi_d, clamp_q, pi_q;
	logic [15:0] pct_q, pct_d;

	// Merge write data into a 16-bit register by byte lane
	function automatic logic [15:0] laneMerge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0])
			r[7:0] = wd[7:0];
		if (be[1])
			r[15:8] = wd[15:8];
		return r;
	endfunction : laneMerge

	// Step of a direction-qualified counter
	function automatic count_t stepCount(input count_t v, input logic down);
		return down ? v - 32'sh0000_0001 : v + 32'sh0000_0001;
	endfunction : stepCount

	// ----------------------------------------
	// Register bus: one wait cycle per access
	// ----------------------------------------
	assign busReq = avsRead | avsWrite;
	assign avsWaitRequest = busReq & ~ack_q;
	assign wrTake = avsWrite & ack_q;

	always_comb
	begin
		ack_d = busReq & ~ack_q;
		rdata_d = rdata_q;
		fsw2_d = fsw2_q;
		cms_d = cms_q;
		trg_d = trg_q;
		loop_d = loop_q;
		if (avsRead & ~ack_q)
		begin
			case (avsAddress)
				`ADDR_FSW2:   rdata_d = {16'h0000, fsw2_q};
				`ADDR_CMS:    rdata_d = {16'h0000, cms_q};
				`ADDR_TRG:    rdata_d = {16'h0000, trg_q};
				`ADDR_LOOP:   rdata_d = {30'h0000_0000, loop_q};
				`ADDR_STATUS: rdata_d = {28'h000_0000, fsw2_q[`FSW2_FILT_OC],
					inhibitSel, pi_q, clamp_q};
				`ADDR_REFCNT: rdata_d = refCnt_q;
				`ADDR_POSERR: rdata_d = posError;
				`ADDR_REFSPD: rdata_d = refSpd_q;
				default:      rdata_d = 32'h0000_0000;
			endcase
		end
		if (wrTake)
		begin
			case (avsAddress)
				`ADDR_FSW2: fsw2_d = laneMerge(fsw2_q, avsWriteData, avsByteEnable);
				`ADDR_CMS:  cms_d = laneMerge(cms_q, avsWriteData, avsByteEnable);
				`ADDR_TRG:
				begin
					trg_d = laneMerge(trg_q, avsWriteData, avsByteEnable);
					if (trg_d < `TRG_MIN)
						trg_d = `TRG_MIN;
					else if (trg_d > `TRG_MAX)
						trg_d = `TRG_MAX;
				end
				`ADDR_LOOP:
				begin
					if (avsByteEnable[0])
					begin
						case (avsWriteData[1:0])
							2'h1:    loop_d = LOOP_TORQUE;
							2'h2:    loop_d = LOOP_POSITION;
							default: loop_d = LOOP_SPEED;
						endcase
					end
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			fsw2_q <= `FSW2_RESET;
			cms_q <= `CMS_RESET;
			trg_q <= `TRG_RESET;
			loop_q <= LOOP_SPEED;
		end
		else
		begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			fsw2_q <= fsw2_d;
			cms_q <= cms_d;
			trg_q <= trg_d;
			loop_q <= loop_d;
		end
	end

	assign avsReadData = rdata_q;

	// ----------------------------------------
	// Reference input filters
	// ----------------------------------------
	pulse_filter u_pulse_filter
	(
		.clk_sys       (clk_sys),
		.rst           (rst),
		.rawIn         (refPulseIn),
		.openCollector (fsw2_q[`FSW2_FILT_OC]),
		.cleanOut      (refClean)
	);

	pulse_filter u_dir_filter
	(
		.clk_sys       (clk_sys),
		.rst           (rst),
		.rawIn         (refDirIn),
		.openCollector (fsw2_q[`FSW2_FILT_OC]),
		.cleanOut      (dirClean)
	);

	// ----------------------------------------
	// Inhibit gate and counters
	// ----------------------------------------
	assign inhibitSel = (cms_q == `CMS_INHIBIT);
	assign holdNow = inhibitSel && loop_q == LOOP_POSITION && modeSwitchOn;
	assign refEdge = refClean & ~refPrev_q;
	assign fbEdge = fbPulseIn & ~fbPrev_q;
	assign posError = refCnt_q - fbCnt_q;

	always_comb
	begin
		gate_d = gate_q;
		case (gate_q)
			GATE_COUNT:
				if (holdNow)
					gate_d = GATE_HOLD;
			GATE_HOLD:
				if (!holdNow)
					gate_d = GATE_COUNT;
			default:
				gate_d = GATE_COUNT;
		endcase
		// An edge seen while held is consumed here and never replayed
		refCnt_d = refCnt_q;
		winPulse_d = winPulse_q;
		if (refEdge && !holdNow)
		begin
			refCnt_d = stepCount(refCnt_q, dirClean);
			winPulse_d = stepCount(winPulse_q, dirClean);
		end
		fbCnt_d = fbEdge ? stepCount(fbCnt_q, fbDirIn) : fbCnt_q;
		win_d = win_q + 32'h0000_0001;
		refSpd_d = refSpd_q;
		if (win_q >= 32'(SPD_WIN_CYC - 1))
		begin
			win_d = 32'h0000_0000;
			refSpd_d = winPulse_d;
			winPulse_d = 32'sh0000_0000;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			gate_q <= GATE_COUNT;
			refPrev_q <= 1'b0;
			fbPrev_q <= 1'b0;
			refCnt_q <= 32'sh0000_0000;
			fbCnt_q <= 32'sh0000_0000;
			winPulse_q <= 32'sh0000_0000;
			refSpd_q <= 32'sh0000_0000;
			win_q <= 32'h0000_0000;
		end
		else
		begin
			gate_q <= gate_d;
			refPrev_q <= refClean;
			fbPrev_q <= fbPulseIn;
			refCnt_q <= refCnt_d;
			fbCnt_q <= fbCnt_d;
			winPulse_q <= winPulse_d;
			refSpd_q <= refSpd_d;
			win_q <= win_d;
		end
	end

	// ----------------------------------------
	// Clamp, speed loop mode, torque scaling
	// ----------------------------------------
	always_comb
	begin
		clamp_d = (gate_d == GATE_HOLD);
		if (cms_q == `CMS_PI_LO || cms_q == `CMS_PI_HI)
			pi_d = ~modeSwitchOn;
		else
			pi_d = 1'b1;
		pct_d = torqueLimitMv / trg_q;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			clamp_q <= 1'b0;
			pi_q <= 1'b1;
			pct_q <= 16'h0000;
		end
		else
		begin
			clamp_q <= clamp_d;
			pi_q <= pi_d;
			pct_q <= pct_d;
		end
	end

	assign servoClamp = clamp_q;
	assign speedLoopPi = pi_q;
	assign torqueLimitPct = pct_q;

	// ----------------------------------------
	// Monitor outputs
	// ----------------------------------------
	monitor_select u_monitor_select
	(
		.clk_sys          (clk_sys),
		.rst              (rst),
		.loopMode         (loop_q),
		.trqSel           (fsw2_q[`FSW2_TRQ_SEL]),
		.vtgSel           (fsw2_q[`FSW2_VTG_SEL]),
		.errCoarse        (fsw2_q[`FSW2_ERR_SCALE]),
		.motorTorque      (motorTorque),
		.motorSpeed       (motorSpeed),
		.speedRef         (speedRef),
		.refSpeed         (refSpd_q),
		.posError         (posError),
		.torqueMonitorOut (torqueMonitorOut),
		.speedMonitorOut  (speedMonitorOut)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_inhibit_freeze: assert property (@(posedge clk_sys) disable iff (rst)
		holdNow |=> $stable(refCnt_q) && servoClamp)
		else $error("reference count moved while inhibited");

	a_inhibit_mode: assert property (@(posedge clk_sys) disable iff (rst)
		holdNow |-> cms_q == `CMS_INHIBIT)
		else $error("inhibit active outside mode 11");

	a_default_count: assert property (@(posedge clk_sys) disable iff (rst)
		cms_q == `CMS_RESET && refEdge && !dirClean
		|=> refCnt_q == $past(refCnt_q) + 32'sh0000_0001)
		else $error("default mode missed a pulse");

	a_pi_forced: assert property (@(posedge clk_sys) disable iff (rst)
		inhibitSel |=> speedLoopPi)
		else $error("speed loop left PI in inhibit mode");

	a_gain_range: assert property (@(posedge clk_sys) disable iff (rst)
		trg_q >= `TRG_MIN && trg_q <= `TRG_MAX)
		else $error("torque gain out of range");

	a_drop_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		(holdNow && refEdge) ##1 (!refEdge) |=> refCnt_q == $past(refCnt_q, 2))
		else $error("inhibited pulse was replayed");

	a_bus_wait: assert property (@(posedge clk_sys) disable iff (rst)
		busReq && avsWaitRequest |=> !avsWaitRequest || !busReq)
		else $error("waitrequest held more than one cycle");
endmodule : ref_gate_top

// *** verification/host_pulse_model.sv ***
`timescale 1ns/1ps
module host_pulse_model
(
	// Clock
	input  wire logic clk_sys,
	// Reference pulse pins
	output logic      refPulseIn,
	output logic      refDirIn
);
	initial
	begin
		refPulseIn = 1'b0;
		refDirIn   = 1'b0;
	end

	// Direction settles one cycle ahead of the first pulse edge
	task automatic send(input int n, input logic down, input int hi);
		@(posedge clk_sys);
		refDirIn <= down;
		for (int k = 0; k < n; k++)
		begin
			@(posedge clk_sys);
			refPulseIn <= 1'b1;
			repeat (hi) @(posedge clk_sys);
			refPulseIn <= 1'b0;
			repeat (hi - 1) @(posedge clk_sys);
		end
	endtask : send
endmodule : host_pulse_model

// *** verification/tb_ref_gate_top.sv ***
`timescale 1ns/1ps
`include "ref_gate_cfg.svh"
module tb_ref_gate_top;
	import ref_gate_pkg::*;

	logic        clk_sys;
	logic        rst;
	logic [4:0]  avsAddress;
	logic        avsRead;
	logic        avsWrite;
	logic [31:0] avsWriteData;
	logic [31:0] avsReadData;
	logic        avsWaitRequest;
	logic        refPulseIn;
	logic        refDirIn;
	logic        modeSwitchOn;
	mon_t        motorTorque;
	mon_t        motorSpeed;
	mon_t        speedRef;
	logic [15:0] torqueLimitMv;
	logic        servoClamp;
	logic        speedLoopPi;
	logic [15:0] torqueLimitPct;
	mon_t        torqueMonitorOut;
	mon_t        speedMonitorOut;
	int          compares;
	int          miscompares;

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	ref_gate_top #(.SPD_WIN_CYC(16)) ref_gate_top_i
	(
		.clk_sys(clk_sys), .rst(rst),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(4'h3),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
		.refPulseIn(refPulseIn), .refDirIn(refDirIn),
		.fbPulseIn(1'b0), .fbDirIn(1'b0), .modeSwitchOn(modeSwitchOn),
		.motorTorque(motorTorque), .motorSpeed(motorSpeed), .speedRef(speedRef),
		.torqueLimitMv(torqueLimitMv), .servoClamp(servoClamp),
		.speedLoopPi(speedLoopPi), .torqueLimitPct(torqueLimitPct),
		.torqueMonitorOut(torqueMonitorOut), .speedMonitorOut(speedMonitorOut)
	);

	host_pulse_model host_pulse_model_i
	(
		.clk_sys(clk_sys),
		.refPulseIn(refPulseIn),
		.refDirIn(refDirIn)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avsAddress   <= a;
		avsWriteData <= d;
		avsWrite     <= 1'b1;
		do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
		avsWrite <= 1'b0;
	endtask : bus_write

	task automatic chk_reg(input string what, input logic [4:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		avsAddress <= a;
		avsRead    <= 1'b1;
		do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
		check(what, avsReadData, exp);
		avsRead <= 1'b0;
	endtask : chk_reg

	task automatic cfg(input logic [4:0] a, input logic [31:0] d);
		bus_write(a, d);
		repeat (3) @(posedge clk_sys);
	endtask : cfg

	task automatic pulses(input int n, input logic down, input int hi, input logic [31:0] exp);
		host_pulse_model_i.send(n, down, hi);
		chk_reg("ref count", `ADDR_REFCNT, exp);
	endtask : pulses

	task automatic set_switch(input logic v);
		@(posedge clk_sys);
		modeSwitchOn <= v;
		repeat (3) @(posedge clk_sys);
	endtask : set_switch

	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
		begin
			$display("*** PASS ***");
		end
		else
		begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	initial
	begin
		#700_000;
		miscompares++;
		report_and_stop();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		compares      = 0;
		miscompares   = 0;
		rst           = 1'b1;
		avsAddress    = 5'h00;
		avsRead       = 1'b0;
		avsWrite      = 1'b0;
		avsWriteData  = 32'h0000_0000;
		modeSwitchOn  = 1'b0;
		motorTorque   = 16'sh0123;
		motorSpeed    = 16'sh0456;
		speedRef      = 16'sh0789;
		torqueLimitMv = 16'h0bb8;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		chk_reg("switch word", `ADDR_FSW2, 32'h0000_0000);
		chk_reg("mode selection", `ADDR_CMS, 32'h0000_0000);
		chk_reg("gain", `ADDR_TRG, 32'h0000_001e);
		check("pi at reset", speedLoopPi, 32'h0000_0001);
		check("limit pct", torqueLimitPct, 32'h0000_0064);
		bus_write(`ADDR_TRG, 32'h0000_0005);
		chk_reg("gain low", `ADDR_TRG, 32'h0000_000a);
		bus_write(`ADDR_TRG, 32'h0000_00c8);
		chk_reg("gain high", `ADDR_TRG, 32'h0000_0064);
		cfg(`ADDR_TRG, 32'h0000_0032);
		check("limit pct 50", torqueLimitPct, 32'h0000_003c);
		bus_write(`ADDR_TRG, 32'h0000_001e);
		bus_write(`ADDR_LOOP, 32'h0000_0002);
		set_switch(1'b1);
		check("p control", speedLoopPi, 32'h0000_0000);
		pulses(3, 1'b0, 112, 32'h0000_0003);
		check("clamp sel 0", servoClamp, 32'h0000_0000);
		cfg(`ADDR_CMS, 32'h0000_0001);
		check("p control sel 1", speedLoopPi, 32'h0000_0000);
		cfg(`ADDR_CMS, 32'h0000_000a);
		check("clamp sel 10", servoClamp, 32'h0000_0000);
		check("pi sel 10", speedLoopPi, 32'h0000_0001);
		pulses(1, 1'b0, 112, 32'h0000_0004);
		cfg(`ADDR_CMS, 32'h0000_000b);
		check("clamp on", servoClamp, 32'h0000_0001);
		check("pi forced", speedLoopPi, 32'h0000_0001);
		chk_reg("status", `ADDR_STATUS, 32'h0000_0007);
		pulses(2, 1'b0, 112, 32'h0000_0004);
		set_switch(1'b0);
		check("clamp off", servoClamp, 32'h0000_0000);
		pulses(1, 1'b0, 112, 32'h0000_0005);
		pulses(1, 1'b1, 112, 32'h0000_0004);
		// Short glitch passes the fast filter only
		pulses(1, 1'b0, 15, 32'h0000_0005);
		cfg(`ADDR_FSW2, 32'h0000_8000);
		pulses(1, 1'b0, 15, 32'h0000_0005);
		pulses(1, 1'b0, 250, 32'h0000_0006);
		cfg(`ADDR_FSW2, 32'h0000_0000);
		check("torque mon", torqueMonitorOut, 32'h0000_0123);
		check("speed mon", speedMonitorOut, 32'h0000_0456);
		cfg(`ADDR_FSW2, 32'h0000_0080);
		check("error mon", speedMonitorOut, 32'h0000_0006);
		cfg(`ADDR_FSW2, 32'h0000_0040);
		check("ref speed mon", torqueMonitorOut, 32'h0000_0000);
		cfg(`ADDR_LOOP, 32'h0000_0000);
		cfg(`ADDR_FSW2, 32'h0000_00c0);
		chk_reg("switch bits", `ADDR_FSW2, 32'h0000_00c0);
		check("speed ref mon", torqueMonitorOut, 32'h0000_0789);
		check("speed undef", speedMonitorOut, 32'h0000_0000);
		cfg(`ADDR_LOOP, 32'h0000_0001);
		check("torque undef", torqueMonitorOut, 32'h0000_0000);
		cfg(`ADDR_LOOP, 32'h0000_0002);
		cfg(`ADDR_FSW2, 32'h0000_0080);
		pulses(200, 1'b0, 112, 32'h0000_00ce);
		check("fine scale", speedMonitorOut, 32'h0000_00ce);
		cfg(`ADDR_FSW2, 32'h0000_4080);
		check("coarse scale", speedMonitorOut, 32'h0000_0002);
		report_and_stop();
	end
endmodule : tb_ref_gate_top
